// ### core/cmk_base.sv
// base node end: registration, alive, promotion and demotion orders
`timescale 1ns/100ps
module cmk_base import cmk_pkg::*; #(
  parameter int SEC_CYCLES = SEC_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  cmk_link_if.base link,
  input wire logic cmd_valid,
  input wire cmk_msg_e cmd_op,
  input wire logic [NODE_W-1:0] cmd_node,
  input wire logic [TIME_W-1:0] cmd_time,
  input wire logic [ID_W-1:0] cmd_nsid,
  input wire logic [NODES-1:0] node_legacy,
  output logic cmd_refused,
  output logic demote_done,
  output logic local_switch_identifier_free,
  output logic alive_seen
);
  localparam logic [SEC_W-1:0] HOLD_S = SEC_W'(CTRL_FAIL_S + MIN_RETX_S);

  logic [31:0] div_r;
  logic sec_tick_r;
  logic [CNT_W-1:0] tx_r [NODES];
  logic [CNT_W-1:0] rx_r [NODES];
  logic [NODES-1:0] dem_pend_r;
  logic [SEC_W-1:0] hold_r;
  logic [ID_W-1:0] held_sid_r;
  logic rx_alv, rx_dem, refuse, send_cmd;

  // seconds tick shared by the hold timer
  always_ff @(posedge core_clk) begin
    if (rst || div_r == 32'(SEC_CYCLES - 1)) begin
      div_r <= 32'h0000_0000;
    end else begin
      div_r <= div_r + 32'h0000_0001;
    end
    sec_tick_r <= !rst && div_r == 32'(SEC_CYCLES - 1);
  end

  assign rx_alv = link.n_valid && link.n_type == MSG_NODE_ALIVE_MESSAGE;
  assign rx_dem = link.n_valid && link.n_type == MSG_DEMOTE;
  // refusals: legacy peers, held identifier, node alive or none op, or link busy with a reply
  always_comb begin
    refuse = 1'b0;
    if (cmd_op == MSG_MC_LEAVE && node_legacy[cmd_node]) refuse = 1'b1;
    if (cmd_op == MSG_ROBUST && node_legacy[cmd_node]) refuse = 1'b1;
    if (cmd_op == MSG_PROMOTION_REQUEST && hold_r != '0 && cmd_nsid == held_sid_r)
      refuse = 1'b1;
    if (cmd_op == MSG_NODE_ALIVE_MESSAGE || cmd_op == MSG_NONE) refuse = 1'b1;
    if (rx_dem && !dem_pend_r[link.n_node]) refuse = 1'b1;
  end
  assign send_cmd = cmd_valid && !refuse;

  // per-node alive counters
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NODES; i++) begin
      if (rst) begin
        tx_r[i] <= '0;
        rx_r[i] <= '0;
      end else begin
        if (send_cmd && cmd_op == MSG_REGISTRATION_RESPONSE && cmd_node == i) begin
          tx_r[i] <= '0;
          rx_r[i] <= '0;
        end else begin
          if (send_cmd && cmd_op == MSG_BASE_ALIVE_MESSAGE && cmd_node == i)
            tx_r[i] <= cnt_inc(tx_r[i]);
          if (rx_alv && link.n_node == i) rx_r[i] <= cnt_inc(rx_r[i]);
        end
      end
    end
  end

  // outgoing message; a demotion reply takes the link first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link.b_valid <= 1'b0;
      link.b_type <= MSG_NONE;
      link.b_node <= '0;
      link.b_time <= '0;
      link.b_txcnt <= '0;
      link.b_rxcnt <= '0;
      link.b_nsid <= '0;
      link.b_pna <= '0;
    end else begin
      link.b_valid <= 1'b0;
      link.b_pna <= '0;
      if (rx_dem && !dem_pend_r[link.n_node]) begin
        link.b_valid <= 1'b1;
        link.b_type <= MSG_DEMOTE;
        link.b_node <= link.n_node;
        link.b_nsid <= link.n_nsid;
        // counters ride only on base alive, so clear stale values here
        link.b_txcnt <= '0;
        link.b_rxcnt <= '0;
      end else if (send_cmd) begin
        link.b_valid <= 1'b1;
        link.b_type <= cmd_op;
        link.b_node <= cmd_node;
        link.b_time <= cmd_time;
        link.b_nsid <= cmd_nsid;
        link.b_txcnt <= cmd_op == MSG_BASE_ALIVE_MESSAGE ? cnt_inc(tx_r[cmd_node]) : '0;
        link.b_rxcnt <= cmd_op == MSG_BASE_ALIVE_MESSAGE ? rx_r[cmd_node] : '0;
      end
    end
  end

  // demotion bookkeeping and identifier hold
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dem_pend_r <= '0;
      hold_r <= '0;
      held_sid_r <= '0;
      demote_done <= 1'b0;
      local_switch_identifier_free <= 1'b1;
    end else begin
      demote_done <= rx_dem;
      if (send_cmd && cmd_op == MSG_DEMOTE) dem_pend_r[cmd_node] <= 1'b1;
      // only completion clears pending, never a rejection
      if (rx_dem) begin
        dem_pend_r[link.n_node] <= 1'b0;
        hold_r <= HOLD_S;
        held_sid_r <= link.n_nsid;
        local_switch_identifier_free <= 1'b0;
      end else if (sec_tick_r && hold_r != '0) begin
        hold_r <= hold_r - 16'h0001;
        local_switch_identifier_free <= hold_r == 16'h0001;
      end
    end
  end

  // flag pulses to the user
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_refused <= 1'b0;
      alive_seen <= 1'b0;
    end else begin
      cmd_refused <= cmd_valid && refuse;
      alive_seen <= rx_alv;
    end
  end
endmodule

// ### core/cmk_link_if.sv
// message link between base end and node end
`timescale 1ns/100ps
interface cmk_link_if;
  import cmk_pkg::*;
  // base to node
  logic b_valid;
  cmk_msg_e b_type;
  logic [NODE_W-1:0] b_node;
  logic [TIME_W-1:0] b_time;
  logic [CNT_W-1:0] b_txcnt;
  logic [CNT_W-1:0] b_rxcnt;
  logic [ID_W-1:0] b_nsid;
  logic [ID_W-1:0] b_pna;
  // node to base
  logic n_valid;
  cmk_msg_e n_type;
  logic [NODE_W-1:0] n_node;
  logic [CNT_W-1:0] n_txcnt;
  logic [CNT_W-1:0] n_rxcnt;
  logic [ID_W-1:0] n_nsid;
  logic [ID_W-1:0] n_pna;

  modport base (output b_valid, b_type, b_node, b_time, b_txcnt, b_rxcnt,
    b_nsid, b_pna, input n_valid, n_type, n_node, n_txcnt, n_rxcnt, n_nsid,
    n_pna);
  modport node (input b_valid, b_type, b_node, b_time, b_txcnt, b_rxcnt,
    b_nsid, b_pna, output n_valid, n_type, n_node, n_txcnt, n_rxcnt, n_nsid,
    n_pna);
endinterface

// ### core/cmk_node.sv
// service or switch node end: keep-alive, demotion, child table, framing
`timescale 1ns/100ps
module cmk_node import cmk_pkg::*; #(
  parameter int SEC_CYCLES = SEC_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  cmk_link_if.node link,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic child_alv_valid,
  input wire logic [NODE_W-1:0] child_alv_idx,
  output logic registered,
  output logic beacon_en,
  output logic robust_req,
  output logic frame_long,
  output logic [OVH_W-1:0] frame_ovh_cyc
);
  typedef enum logic [1:0] {
    ST_TERMINAL = 2'b01,
    ST_SWITCH = 2'b10
  } cmk_role_e;

  // ==========================================================
  // state
  cmk_role_e role_r;
  logic [31:0] div_r;
  logic sec_tick_r;
  logic [SEC_W-1:0] lut_r [LUT_N];
  logic [SEC_W-1:0] ka_r;
  logic expired_r, legacy_r, long_r, dem_want_r, dem_pend_r;
  logic [2:0] scheme_r;
  logic [CNT_W-1:0] tx_r, rx_r;
  logic [ID_W-1:0] sid_r;
  logic [NODE_W-1:0] node_r;
  logic [NODES-1:0] child_ok_r;
  logic [SEC_W-1:0] child_tmo_r [NODES];
  logic [SEC_W-1:0] child_cnt_r [NODES];
  logic hit, other, w_ctrl, w_stat, dem_in, dem_ack, dem_out;

  assign hit = link.b_valid && link.b_node == node_r;
  assign other = link.b_valid && link.b_node != node_r;
  assign w_ctrl = reg_wr && reg_addr == REG_CTRL;
  assign w_stat = reg_wr && reg_addr == REG_STAT;
  // demotion must name our own switch identifier
  assign dem_in = hit && link.b_type == MSG_DEMOTE && link.b_nsid == sid_r
    && role_r == ST_SWITCH;
  // a peer-started demotion is acknowledged; ours just completes
  assign dem_ack = dem_in && !dem_pend_r;
  assign dem_out = dem_want_r && !dem_ack
    && !(hit && link.b_type == MSG_BASE_ALIVE_MESSAGE);

  // ==========================================================
  // one-second tick: timers count seconds, so they never overflow
  always_ff @(posedge core_clk) begin
    if (rst || div_r == 32'(SEC_CYCLES - 1)) begin
      div_r <= 32'h0000_0000;
    end else begin
      div_r <= div_r + 32'h0000_0001;
    end
    sec_tick_r <= !rst && div_r == 32'(SEC_CYCLES - 1);
  end

  // ==========================================================
  // software control registers and lookup table
  always_ff @(posedge core_clk) begin
    if (rst) begin
      legacy_r <= 1'b0;
      long_r <= 1'b0;
      scheme_r <= SCHEME_RST;
      node_r <= '0;
      for (int i = 0; i < LUT_N; i++) lut_r[i] <= LUT_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        legacy_r <= reg_wdata[CTRL_LEGACY_BIT];
        long_r <= reg_wdata[CTRL_LONG_BIT];
      end
      if (reg_addr == REG_SCHEME) scheme_r <= reg_wdata[2:0];
      if (reg_addr == REG_NODE) node_r <= reg_wdata[NODE_W-1:0];
      if (reg_addr >= REG_LUT) lut_r[reg_addr[2:0]] <= reg_wdata;
    end
  end

  // ==========================================================
  // keep-alive timer and registration status
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ka_r <= '0;
      registered <= 1'b0;
      expired_r <= 1'b0;
    end else begin
      if (w_stat && reg_wdata[STAT_EXP_BIT]) expired_r <= 1'b0;
      if (hit && link.b_type == MSG_REGISTRATION_RESPONSE) begin
        ka_r <= lut_r[link.b_time];
        registered <= 1'b1;
      end else if (hit && (link.b_type == MSG_BASE_ALIVE_MESSAGE
          || link.b_type == MSG_PROMOTION_REQUEST)) begin
        ka_r <= lut_r[link.b_time];
      end else if (sec_tick_r && registered && ka_r != '0) begin
        ka_r <= ka_r - 16'h0001;
        // expiry drops registration; set beats clear
        if (ka_r == 16'h0001) begin
          registered <= 1'b0;
          expired_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // alive counters
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_r <= '0;
      rx_r <= '0;
    end else if (hit && link.b_type == MSG_REGISTRATION_RESPONSE) begin
      tx_r <= '0;
      rx_r <= '0;
    end else if (hit && link.b_type == MSG_BASE_ALIVE_MESSAGE) begin
      rx_r <= cnt_inc(rx_r);
      tx_r <= cnt_inc(tx_r);
    end
  end

  // ==========================================================
  // switching role, promotion and demotion
  always_ff @(posedge core_clk) begin
    if (rst) begin
      role_r <= ST_TERMINAL;
      beacon_en <= 1'b0;
      sid_r <= NSID_ALL_ONES;
      dem_want_r <= 1'b0;
      dem_pend_r <= 1'b0;
    end else begin
      if (hit && link.b_type == MSG_PROMOTION_REQUEST && link.b_nsid != NSID_ALL_ONES)
      begin
        role_r <= ST_SWITCH;
        beacon_en <= 1'b1;
        sid_r <= link.b_nsid;
      end
      if (w_ctrl && reg_wdata[CTRL_DEMOTE_BIT] && role_r == ST_SWITCH
          && !dem_pend_r) dem_want_r <= 1'b1;
      if (dem_out) begin
        dem_want_r <= 1'b0;
        dem_pend_r <= 1'b1;
      end
      // demotion done: beacons off, terminal role
      // nothing but completion or expiry ends a wait
      if (dem_in || (sec_tick_r && ka_r == 16'h0001)) begin
        role_r <= ST_TERMINAL;
        beacon_en <= 1'b0;
        dem_want_r <= 1'b0;
        dem_pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // outgoing messages: alive reply, demotion ack, own demotion
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link.n_valid <= 1'b0;
      link.n_type <= MSG_NONE;
      link.n_node <= '0;
      link.n_txcnt <= '0;
      link.n_rxcnt <= '0;
      link.n_nsid <= '0;
      link.n_pna <= '0;
    end else begin
      link.n_valid <= 1'b0;
      link.n_node <= node_r;
      link.n_pna <= '0;
      if (hit && link.b_type == MSG_BASE_ALIVE_MESSAGE) begin
        link.n_valid <= 1'b1;
        link.n_type <= MSG_NODE_ALIVE_MESSAGE;
        link.n_txcnt <= cnt_inc(tx_r);
        link.n_rxcnt <= cnt_inc(rx_r);
      end else if (dem_ack || dem_out) begin
        link.n_valid <= 1'b1;
        link.n_type <= MSG_DEMOTE;
        link.n_nsid <= sid_r;
      end
    end
  end

  // ==========================================================
  // children below this switch; entries lapse without node alive
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NODES; i++) begin
      if (rst || role_r != ST_SWITCH) begin
        child_ok_r[i] <= 1'b0;
        child_tmo_r[i] <= '0;
        child_cnt_r[i] <= '0;
      // copy promotion and alive time per child
      end else if (other && link.b_node == i && (link.b_type == MSG_PROMOTION_REQUEST
          || link.b_type == MSG_BASE_ALIVE_MESSAGE)) begin
        child_ok_r[i] <= 1'b1;
        child_tmo_r[i] <= lut_r[link.b_time];
        child_cnt_r[i] <= lut_r[link.b_time];
      end else if (child_alv_valid && child_alv_idx == i) begin
        child_cnt_r[i] <= child_tmo_r[i];
      end else if (sec_tick_r && child_ok_r[i]) begin
        // no node alive in time: drop entry
        child_cnt_r[i] <= child_cnt_r[i] - 16'h0001;
        if (child_cnt_r[i] <= 16'h0001) child_ok_r[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // frame format and robustness requests
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_long <= 1'b0;
      frame_ovh_cyc <= OVH_W'(OVH_A_CYC);
      robust_req <= 1'b0;
    end else begin
      // robust schemes force the long frame
      frame_long <= long_r || is_robust(scheme_r);
      frame_ovh_cyc <= (long_r || is_robust(scheme_r)) ?
        OVH_W'(OVH_B_CYC) : OVH_W'(OVH_A_CYC);
      robust_req <= hit && link.b_type == MSG_ROBUST && !legacy_r;
    end
  end

  // ==========================================================
  // register read, data one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {13'h0000, long_r, legacy_r, 1'b0};
        REG_STAT: reg_rdata <= {11'h000, dem_pend_r, expired_r, beacon_en,
          role_r == ST_SWITCH, registered};
        REG_KA: reg_rdata <= ka_r;
        REG_CNT: reg_rdata <= {tx_r, rx_r};
        REG_SCHEME: reg_rdata <= {13'h0000, scheme_r};
        REG_CHILD: reg_rdata <= {12'h000, child_ok_r};
        REG_SID: reg_rdata <= {8'h00, sid_r};
        REG_NODE: reg_rdata <= {14'h0000, node_r};
        default: reg_rdata <= reg_addr >= REG_LUT ?
          lut_r[reg_addr[2:0]] : 16'h0000;
      endcase
    end
  end
endmodule

// ### core/cmk_pkg.sv
// constants, message types and helpers shared by both link ends
package cmk_pkg;
  localparam int CNT_W = 8;
  localparam int ID_W = 8;
  localparam int TIME_W = 3;
  localparam int NODE_W = 2;
  localparam int NODES = 4;
  localparam int LUT_N = 8;
  localparam int SEC_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int OVH_W = 21;

  typedef enum logic [2:0] {
    MSG_REGISTRATION_RESPONSE = 3'h0,
    MSG_BASE_ALIVE_MESSAGE = 3'h1,
    MSG_NODE_ALIVE_MESSAGE = 3'h2,
    MSG_PROMOTION_REQUEST = 3'h3,
    MSG_DEMOTE = 3'h4,
    MSG_MC_LEAVE = 3'h5,
    MSG_ROBUST = 3'h6,
    MSG_NONE = 3'h7
  } cmk_msg_e;

  localparam logic [ID_W-1:0] NSID_ALL_ONES = 8'hFF;

  // node register map
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] REG_KA = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CNT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_SCHEME = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CHILD = 4'h5;
  localparam logic [ADDR_W-1:0] REG_SID = 4'h6;
  localparam logic [ADDR_W-1:0] REG_NODE = 4'h7;
  localparam logic [ADDR_W-1:0] REG_LUT = 4'h8;
  localparam int CTRL_DEMOTE_BIT = 0;
  localparam int CTRL_LEGACY_BIT = 1;
  localparam int CTRL_LONG_BIT = 2;
  localparam int STAT_REG_BIT = 0;
  localparam int STAT_SW_BIT = 1;
  localparam int STAT_BCN_BIT = 2;
  localparam int STAT_EXP_BIT = 3;
  localparam int STAT_DEM_BIT = 4;
  localparam logic [SEC_W-1:0] LUT_RST = 16'h003C;
  localparam logic [2:0] SCHEME_RST = 3'h2;

  // payload schemes; codes below 3'h2 are the robust ones
  localparam logic [2:0] SCH_ROBUST_LIMIT = 3'h2;

  // frame timing
  localparam int CLK_NS = 10;
  localparam int SEC_NS = 1000000000;
  localparam int SEC_CYC = SEC_NS / CLK_NS;
  localparam int PRE_A_NS = 2048000;
  localparam int PRE_B_NS = 8192000;
  localparam int SYM_NS = 2240000;
  localparam int HDR_A_SYMS = 2;
  localparam int HDR_B_SYMS = 4;
  localparam int OVH_A_CYC = (PRE_A_NS + HDR_A_SYMS * SYM_NS) / CLK_NS;
  localparam int OVH_B_CYC = (PRE_B_NS + HDR_B_SYMS * SYM_NS) / CLK_NS;

  // demoted identifier hold, seconds (plain defaults)
  localparam int CTRL_FAIL_S = 10;
  localparam int MIN_RETX_S = 2;

  function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] c);
    cnt_inc = c + 8'h01;
  endfunction

  function automatic logic is_robust(input logic [2:0] sch);
    is_robust = sch < SCH_ROBUST_LIMIT;
  endfunction
endpackage

// ### tb/cmk_sva.sv
// concurrent checks on the message link between the two ends
`timescale 1ns/100ps
module cmk_sva import cmk_pkg::*; #(
  parameter logic [NODE_W-1:0] NODE_IDX = 2'h0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic b_valid,
  input wire cmk_msg_e b_type,
  input wire logic [NODE_W-1:0] b_node,
  input wire logic [CNT_W-1:0] b_txcnt,
  input wire logic [CNT_W-1:0] b_rxcnt,
  input wire logic [ID_W-1:0] b_nsid,
  input wire logic [ID_W-1:0] b_pna,
  input wire logic n_valid,
  input wire cmk_msg_e n_type,
  input wire logic [CNT_W-1:0] n_txcnt,
  input wire logic [CNT_W-1:0] n_rxcnt,
  input wire logic [ID_W-1:0] n_nsid,
  input wire logic [ID_W-1:0] n_pna
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ========================================
  // helper state
  logic [ID_W-1:0] sid_r;
  logic sw_r;
  logic fresh_r;
  logic b_me;
  assign b_me = b_valid && b_node == NODE_IDX;
  // granted identifier and role; fresh marks counters just cleared
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sid_r <= 8'hFF;
      sw_r <= 1'b0;
      fresh_r <= 1'b0;
    end else begin
      if (b_me && b_type == MSG_PROMOTION_REQUEST && b_nsid != NSID_ALL_ONES) begin
        sid_r <= b_nsid;
        sw_r <= 1'b1;
      end else if (n_valid && n_type == MSG_DEMOTE) begin
        sw_r <= 1'b0;
      end
      if (b_me && b_type == MSG_REGISTRATION_RESPONSE) begin
        fresh_r <= 1'b1;
      end else if (b_me && b_type == MSG_BASE_ALIVE_MESSAGE) begin
        fresh_r <= 1'b0;
      end
    end
  end
  // ========================================
  // sequences and properties
  sequence s_alv_req;
    b_me && b_type == MSG_BASE_ALIVE_MESSAGE;
  endsequence
  // counters are only in step when alive requests are not back to back
  sequence s_alv_rsp;
    n_valid && n_type == MSG_NODE_ALIVE_MESSAGE && n_rxcnt == $past(b_txcnt)
      && n_txcnt == $past(b_rxcnt) + 8'h01;
  endsequence
  property p_alv_reply;
    s_alv_req |=> s_alv_rsp;
  endproperty
  a_alv_reply: assert property (p_alv_reply)
    else $error("alive reply missing or counters wrong");
  property p_pna_zero;
    (b_valid || n_valid) |-> (b_pna | n_pna) == 8'h00;
  endproperty
  a_pna_zero: assert property (p_pna_zero)
    else $error("promoted node address not zero");
  property p_demote_sid;
    n_valid && n_type == MSG_DEMOTE |-> n_nsid == sid_r;
  endproperty
  a_demote_sid: assert property (p_demote_sid)
    else $error("demotion names wrong switch");
  property p_demote_ack;
    b_me && b_type == MSG_DEMOTE && b_nsid == sid_r && sw_r
      |=> n_valid && n_type == MSG_DEMOTE;
  endproperty
  a_demote_ack: assert property (p_demote_ack)
    else $error("demotion not acknowledged");
  property p_node_types;
    n_valid |-> n_type inside {MSG_NODE_ALIVE_MESSAGE, MSG_DEMOTE};
  endproperty
  a_node_types: assert property (p_node_types)
    else $error("node sent unexpected message");
  property p_base_types;
    b_valid |-> !(b_type inside {MSG_NODE_ALIVE_MESSAGE, MSG_NONE});
  endproperty
  a_base_types: assert property (p_base_types)
    else $error("base sent unexpected message");
  property p_fresh_cnt;
    s_alv_req and fresh_r |-> b_txcnt == 8'h01 && b_rxcnt == 8'h00;
  endproperty
  a_fresh_cnt: assert property (p_fresh_cnt)
    else $error("counters not cleared at registration");
  property p_cnt_idle;
    b_valid && b_type != MSG_BASE_ALIVE_MESSAGE |-> (b_txcnt | b_rxcnt) == 8'h00;
  endproperty
  a_cnt_idle: assert property (p_cnt_idle)
    else $error("counters on non alive message");
endmodule

// ### tb/tb.sv
// self-checking bench joining the base end and the node end
`timescale 1ns/100ps
module tb;
  import cmk_pkg::*;
  localparam int SC = 100;
  localparam int OVH_S = (2048000 + 2 * 2240000) / 10;
  localparam int OVH_L = (8192000 + 4 * 2240000) / 10;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  cmk_msg_e cmd_op = MSG_NONE;
  logic [TIME_W-1:0] cmd_time = 3'h0;
  logic [ID_W-1:0] cmd_nsid = 8'hFF;
  logic [NODES-1:0] node_legacy = 4'h0;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] rv;
  logic registered, beacon_en, robust_req, frame_long;
  logic cmd_refused, demote_done, local_switch_identifier_free, alive_seen;
  logic [OVH_W-1:0] frame_ovh_cyc;
  int bad_count = 0;
  int check_count = 0;
  int pc[4] = '{0, 0, 0, 0};
  int n;
  int k;
  // ========================================
  // clock, pulse counters, instances
  always #5 core_clk = ~core_clk;
  // pulses are counted so checks need not hit their exact cycle
  always @(posedge core_clk) begin
    pc[0] <= pc[0] + int'(cmd_refused === 1'b1);
    pc[1] <= pc[1] + int'(demote_done === 1'b1);
    pc[2] <= pc[2] + int'(robust_req === 1'b1);
    pc[3] <= pc[3] + int'(alive_seen === 1'b1);
  end
  cmk_link_if link ();
  cmk_base #(.SEC_CYCLES(SC)) i_cmk_base (.core_clk(core_clk), .rst(rst),
    .link(link), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_node(2'h0),
    .cmd_time(cmd_time), .cmd_nsid(cmd_nsid), .node_legacy(node_legacy),
    .cmd_refused(cmd_refused), .demote_done(demote_done),
    .local_switch_identifier_free(local_switch_identifier_free), .alive_seen(alive_seen));
  cmk_node #(.SEC_CYCLES(SC)) i_cmk_node (.core_clk(core_clk), .rst(rst),
    .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .child_alv_valid(1'b0), .child_alv_idx(2'h0), .registered(registered),
    .beacon_en(beacon_en), .robust_req(robust_req),
    .frame_long(frame_long), .frame_ovh_cyc(frame_ovh_cyc));
  cmk_sva i_cmk_sva (.core_clk(core_clk), .rst(rst),
    .b_valid(link.b_valid), .b_type(link.b_type), .b_node(link.b_node),
    .b_txcnt(link.b_txcnt), .b_rxcnt(link.b_rxcnt), .b_nsid(link.b_nsid),
    .b_pna(link.b_pna), .n_valid(link.n_valid), .n_type(link.n_type),
    .n_txcnt(link.n_txcnt), .n_rxcnt(link.n_rxcnt), .n_nsid(link.n_nsid),
    .n_pna(link.n_pna));
  // ========================================
  // tasks
  task automatic conclude();
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic cmd(input cmk_msg_e op, input logic [ID_W-1:0] id,
    input logic [TIME_W-1:0] t);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_time <= t;
    cmd_nsid <= id;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask
  // bounded wait on registered, beacon_en or local_switch_identifier_free
  task automatic await(input int s, input logic v, input int lim);
    n = 0;
    while ((s == 0 ? registered : s == 1 ? beacon_en : local_switch_identifier_free) !== v) begin
      if (n == lim) begin
        bad_count++;
        conclude();
      end
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  // ========================================
  // main sequence
  initial begin
    cyc(2);
    rst <= 1'b0;
    rd(REG_LUT);
    chk("lut_rst", 16'h003C, rv);
    rd(REG_SID);
    chk("sid_rst", 16'h00FF, rv);
    chk("ovh_short", OVH_S, frame_ovh_cyc);
    wr(REG_LUT + 4'h1, 16'h0005);
    wr(REG_LUT + 4'h2, 16'h0009);
    cmd(MSG_REGISTRATION_RESPONSE, 8'hFF, 3'h1);
    cyc(3);
    chk("registered", 1, registered);
    rd(REG_KA);
    chk("ka_reg", 1, rv inside {16'h0004, 16'h0005});
    k = pc[3];
    cmd(MSG_BASE_ALIVE_MESSAGE, 8'hFF, 3'h0);
    cyc(4);
    chk("alive_seen", k + 1, pc[3]);
    rd(REG_CNT);
    chk("cnt", 16'h0101, rv);
    rd(REG_KA);
    chk("ka_alv", 1, rv inside {16'h003B, 16'h003C});
    cmd(MSG_REGISTRATION_RESPONSE, 8'hFF, 3'h1);
    cyc(3);
    rd(REG_CNT);
    chk("cnt_clr", 16'h0000, rv);
    await(0, 1'b0, 7 * SC);
    chk("expiry_time", 1, n >= 3 * SC);
    rd(REG_STAT);
    chk("stat_exp", 1, rv[STAT_EXP_BIT]);
    cmd(MSG_REGISTRATION_RESPONSE, 8'hFF, 3'h1);
    cmd(MSG_PROMOTION_REQUEST, 8'h21, 3'h2);
    cyc(3);
    chk("beacon_on", 1, beacon_en);
    rd(REG_KA);
    chk("ka_pro", 1, rv inside {16'h0008, 16'h0009});
    cmd(MSG_DEMOTE, 8'h30, 3'h0);
    cyc(4);
    chk("keep_switch", 1, beacon_en);
    k = pc[1];
    cmd(MSG_DEMOTE, 8'h21, 3'h0);
    await(1, 1'b0, 8);
    cyc(3);
    chk("demote_done", k + 1, pc[1]);
    chk("local_switch_identifier_hold", 0, local_switch_identifier_free);
    k = pc[0];
    cmd(MSG_PROMOTION_REQUEST, 8'h21, 3'h2);
    cyc(3);
    chk("reuse_refused", k + 1, pc[0]);
    await(2, 1'b1, 14 * SC);
    chk("hold_len", 1, n >= 11 * SC);
    cmd(MSG_PROMOTION_REQUEST, 8'h22, 3'h2);
    cyc(3);
    wr(REG_CTRL, 16'h0001);
    await(1, 1'b0, 10);
    rd(REG_STAT);
    chk("terminal", 0, rv[STAT_SW_BIT]);
    @(posedge core_clk);
    node_legacy <= 4'h1;
    k = pc[0];
    cmd(MSG_MC_LEAVE, 8'hFF, 3'h0);
    cmd(MSG_ROBUST, 8'hFF, 3'h0);
    cyc(3);
    chk("legacy_refused", k + 2, pc[0]);
    node_legacy <= 4'h0;
    k = pc[2];
    cmd(MSG_ROBUST, 8'hFF, 3'h0);
    cyc(4);
    chk("robust_req", k + 1, pc[2]);
    wr(REG_CTRL, 16'h0002);
    cmd(MSG_ROBUST, 8'hFF, 3'h0);
    cyc(4);
    chk("robust_legacy", k + 1, pc[2]);
    // robust codes must force the long frame, the rest stay short
    for (int s = 7; s >= 0; s--) begin
      wr(REG_SCHEME, 16'(s));
      cyc(2);
      chk("scheme_long", s < 2, frame_long);
    end
    chk("ovh_long", OVH_L, frame_ovh_cyc);
    wr(REG_SCHEME, 16'h0003);
    wr(REG_CTRL, 16'h0004);
    cyc(2);
    chk("forced_long", 1, frame_long);
    conclude();
  end
endmodule
